// File: rtl/plr_pkg.sv
// Purpose: Shared constants and types for the programmable register macrocell fabric
// Assumes: AHB-Lite register access, one 125 MHz system clock, synchronous pins
// Notes: Fuse words are 32 bits; each product term takes three consecutive words
package plr_pkg;
    localparam int NUM_REG = 20;
    localparam int NUM_IO = 10;
    localparam int NUM_DIN = 11;
    localparam int ARRAY_W = NUM_DIN + 1 + NUM_IO + NUM_REG;
    localparam int SUM_PT = 2;
    localparam int TERM_PER_REG = SUM_PT + 2;
    localparam int TERM_W = 2 * ARRAY_W;
    localparam int WORD_PER_TERM = 3;
    localparam int OE_TERM_BASE = NUM_REG * TERM_PER_REG;
    localparam int PRESET_TERM = OE_TERM_BASE + NUM_IO;
    localparam int NUM_TERM = PRESET_TERM + 1;
    localparam int NUM_WORD = NUM_TERM * WORD_PER_TERM;
    localparam int FUSE_AW = 9;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] FUSE_BASE_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] REG_TYPE_OFS = 12'h800;
    localparam logic [ADDR_W-1:0] REG_CLKSEL_OFS = 12'h804;
    localparam logic [ADDR_W-1:0] REG_SECURE_OFS = 12'h808;
    localparam logic [ADDR_W-1:0] REG_STATE_OFS = 12'h80c;
    localparam logic [ADDR_W-1:0] REG_OESTATE_OFS = 12'h810;

    // Reset values and the word a secured fuse read returns
    localparam logic [NUM_REG-1:0] CFG_TYPE_RST = 20'h00000;
    localparam logic [NUM_REG-1:0] CFG_CLKSEL_RST = 20'h00000;
    localparam logic [DATA_W-1:0] FUSE_RST = 32'h00000000;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h00000000;
    localparam logic [DATA_W-1:0] MASK_WORD = 32'hffffffff;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_RDWAIT = 2'b01,
        BUS_RDOUT = 2'b10
    } plr_bus_t;
endpackage

// File: rtl/plr_fuse_mem.sv
// Purpose: Fuse store for the product-term array with a registered read port
// Assumes: One write and one read per clock
// Notes: All words are also presented in parallel so every term evaluates at once
`timescale 1ns/1ns
module plr_fuse_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 273,
    parameter int AW = 9
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Write port
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    // Read port
    input wire logic rdEn,
    input wire logic [AW-1:0] rdAddr,
    input wire logic rdMask,
    output logic [WIDTH-1:0] rdData,
    // Whole array
    output logic [WIDTH*DEPTH-1:0] allData
);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] rdData_ff;

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : gWord
            assign allData[g*WIDTH +: WIDTH] = mem_ff[g];
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    mem_ff[g] <= '0;
                end else if (wrEn && (wrAddr == AW'(g))) begin
                    mem_ff[g] <= wrData;
                end
            end
        end
    endgenerate

    // Secured array reads back as fully programmed
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdData_ff <= '0;
        end else if (rdEn) begin
            rdData_ff <= rdMask ? '1 : mem_ff[rdAddr];
        end
    end

    assign rdData = rdData_ff;
endmodule

// File: rtl/plr_macrocell.sv
// Purpose: One configurable master-slave register of the fabric
// Assumes: Clock sources are levels sampled on clk_sys; edges are found here
// Notes: Register clock rate must not exceed half of clk_sys to be seen
`timescale 1ns/1ns
module plr_macrocell (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Private terms
    input wire logic sumTerm,
    input wire logic resetTerm,
    input wire logic clkTerm,
    // Shared inputs
    input wire logic clkPin,
    input wire logic presetReq,
    // Configuration
    input wire logic cfgToggle,
    input wire logic cfgPinClk,
    // State
    output logic q
);
    logic master_ff;
    logic q_ff;
    logic clkPrev_ff;
    wire regClk = cfgPinClk ? clkPin : clkTerm;
    wire regRise = regClk & ~clkPrev_ff;
    wire dataNext = cfgToggle ? (q_ff ^ sumTerm) : sumTerm;
    // Preset only lands if the board raises this register's clock meanwhile
    wire nxt_master = presetReq ? 1'b1 : dataNext;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            clkPrev_ff <= 1'b0;
        end else begin
            clkPrev_ff <= regClk;
        end
    end

    // Reset term wins over everything, no register clock needed
    always_ff @(posedge clk_sys) begin
        if (sys_rst || resetTerm) begin
            master_ff <= 1'b0;
            q_ff <= 1'b0;
        end else begin
            if (!regClk) begin
                master_ff <= nxt_master;
            end
            if (regRise) begin
                q_ff <= master_ff;
            end
        end
    end

    assign q = q_ff;
endmodule

// File: rtl/plr_fabric.sv
// Purpose: Twenty-register programmable macrocell fabric with AHB-Lite fuse access
// Assumes: Pins are synchronous to clk_sys; single-word AHB-Lite transfers only
// Notes: Term results reach registers and output enables one clk_sys later
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module plr_fabric (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Device pins
    input wire logic clkPin,
    input wire logic [plr_pkg::NUM_DIN-1:0] inPin,
    input wire logic [plr_pkg::NUM_IO-1:0] ioIn,
    output logic [plr_pkg::NUM_IO-1:0] ioOut,
    output logic [plr_pkg::NUM_IO-1:0] ioOe
);
    // One product term: AND over every array input, true and complement fuses
    function automatic logic ptEval(input logic [plr_pkg::TERM_W-1:0] f,
                                    input logic [plr_pkg::ARRAY_W-1:0] x);
        logic r;
        r = 1'b1;
        for (int k = 0; k < plr_pkg::ARRAY_W; k++) begin
            r = r & (~f[2*k] | x[k]) & (~f[2*k+1] | ~x[k]);
        end
        return r;
    endfunction

    function automatic logic isFuse(input logic [plr_pkg::ADDR_W-1:0] a);
        return (a[11] == 1'b0) && (a[10:2] < plr_pkg::FUSE_AW'(plr_pkg::NUM_WORD));
    endfunction

    // Bus state
    plr_pkg::plr_bus_t busState_ff;
    logic [plr_pkg::ADDR_W-1:0] addr_ff;
    logic wrPend_ff;
    logic hreadyout_ff;
    logic [31:0] hrdata_ff;
    logic [31:0] ctrlRd_ff;
    logic hresp_ff;
    // Configuration and status
    logic [plr_pkg::NUM_REG-1:0] cfgType_ff;
    logic [plr_pkg::NUM_REG-1:0] cfgPinClk_ff;
    logic secure_ff;
    logic [plr_pkg::NUM_IO-1:0] ioOe_ff;
    // Array
    logic [plr_pkg::NUM_REG-1:0] regQ;
    logic [plr_pkg::NUM_TERM-1:0] termHit;
    logic [plr_pkg::DATA_W*plr_pkg::NUM_WORD-1:0] fuseAll;
    logic [31:0] memRd;

    wire addrTaken = hsel & htrans[1] & hready;
    wire wrCommit = wrPend_ff;
    wire fuseWr = wrCommit & isFuse(addr_ff);
    wire typeWr = wrCommit & (addr_ff == plr_pkg::REG_TYPE_OFS);
    wire clkSelWr = wrCommit & (addr_ff == plr_pkg::REG_CLKSEL_OFS);
    wire secureWr = wrCommit & (addr_ff == plr_pkg::REG_SECURE_OFS);
    wire rdStart = (busState_ff == plr_pkg::BUS_RDWAIT);
    wire [plr_pkg::FUSE_AW-1:0] wordIdx = addr_ff[10:2];

    // Array inputs: pins, separate I/O input path and every register fed back
    wire [plr_pkg::ARRAY_W-1:0] arrIn = {regQ, ioIn, clkPin, inPin};

    // Control read mux; configuration fuses read as programmed once secured
    wire [plr_pkg::NUM_REG-1:0] typeView = secure_ff ? '1 : cfgType_ff;
    wire [plr_pkg::NUM_REG-1:0] clkSelView = secure_ff ? '1 : cfgPinClk_ff;
    wire [31:0] ctrlRdVal =
        (addr_ff == plr_pkg::REG_TYPE_OFS) ? {12'h000, typeView} :
        (addr_ff == plr_pkg::REG_CLKSEL_OFS) ? {12'h000, clkSelView} :
        (addr_ff == plr_pkg::REG_SECURE_OFS) ? {31'h00000000, secure_ff} :
        (addr_ff == plr_pkg::REG_STATE_OFS) ? {12'h000, regQ} :
        (addr_ff == plr_pkg::REG_OESTATE_OFS) ? {22'h000000, ioOe_ff} :
        plr_pkg::RDATA_RST;

    plr_fuse_mem #(
        .WIDTH(plr_pkg::DATA_W),
        .DEPTH(plr_pkg::NUM_WORD),
        .AW(plr_pkg::FUSE_AW)
    ) uFuse (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .wrEn(fuseWr),
        .wrAddr(wordIdx),
        .wrData(hwdata),
        .rdEn(rdStart),
        .rdAddr(wordIdx),
        .rdMask(secure_ff),
        .rdData(memRd),
        .allData(fuseAll)
    );

    // Every term evaluates from its own three fuse words
    genvar t;
    generate
        for (t = 0; t < plr_pkg::NUM_TERM; t++) begin : gTerm
            wire [plr_pkg::DATA_W*plr_pkg::WORD_PER_TERM-1:0] termWords =
                fuseAll[t*plr_pkg::DATA_W*plr_pkg::WORD_PER_TERM +:
                        plr_pkg::DATA_W*plr_pkg::WORD_PER_TERM];
            assign termHit[t] = ptEval(termWords[plr_pkg::TERM_W-1:0], arrIn);
        end
    endgenerate

    wire presetReq = termHit[plr_pkg::PRESET_TERM];

    // One register per cell, two per pin; the even one of each pair drives the pin
    genvar r;
    generate
        for (r = 0; r < plr_pkg::NUM_REG; r++) begin : gReg
            localparam int TB = r * plr_pkg::TERM_PER_REG;
            wire sumHit = |termHit[TB +: plr_pkg::SUM_PT];
            plr_macrocell uCell (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .sumTerm(sumHit),
                .resetTerm(termHit[TB + plr_pkg::SUM_PT]),
                .clkTerm(termHit[TB + plr_pkg::SUM_PT + 1]),
                .clkPin(clkPin),
                .presetReq(presetReq),
                .cfgToggle(cfgType_ff[r]),
                .cfgPinClk(cfgPinClk_ff[r]),
                .q(regQ[r])
            );
        end
    endgenerate

    genvar p;
    generate
        for (p = 0; p < plr_pkg::NUM_IO; p++) begin : gPin
            assign ioOut[p] = regQ[2*p];
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    ioOe_ff[p] <= 1'b0;
                end else begin
                    ioOe_ff[p] <= termHit[plr_pkg::OE_TERM_BASE + p];
                end
            end
        end
    endgenerate

    // Configuration registers; security only clears with system reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cfgType_ff <= plr_pkg::CFG_TYPE_RST;
            cfgPinClk_ff <= plr_pkg::CFG_CLKSEL_RST;
            secure_ff <= 1'b0;
        end else begin
            if (typeWr) begin
                cfgType_ff <= hwdata[plr_pkg::NUM_REG-1:0];
            end
            if (clkSelWr) begin
                cfgPinClk_ff <= hwdata[plr_pkg::NUM_REG-1:0];
            end
            if (secureWr && hwdata[0]) begin
                secure_ff <= 1'b1;
            end
        end
    end

    // Writes complete with no wait; reads take two wait states so the
    // fuse read port and the mux both come from flops
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            busState_ff <= plr_pkg::BUS_IDLE;
            addr_ff <= plr_pkg::FUSE_BASE_OFS;
            wrPend_ff <= 1'b0;
            hreadyout_ff <= 1'b1;
            hrdata_ff <= plr_pkg::RDATA_RST;
            ctrlRd_ff <= plr_pkg::RDATA_RST;
            hresp_ff <= 1'b0;
        end else begin
            hresp_ff <= 1'b0;
            case (busState_ff)
                plr_pkg::BUS_IDLE: begin
                    wrPend_ff <= addrTaken & hwrite;
                    if (addrTaken) begin
                        addr_ff <= {haddr[plr_pkg::ADDR_W-1:2], 2'b00};
                        if (!hwrite) begin
                            busState_ff <= plr_pkg::BUS_RDWAIT;
                            hreadyout_ff <= 1'b0;
                        end
                    end
                end
                plr_pkg::BUS_RDWAIT: begin
                    wrPend_ff <= 1'b0;
                    ctrlRd_ff <= ctrlRdVal;
                    busState_ff <= plr_pkg::BUS_RDOUT;
                end
                plr_pkg::BUS_RDOUT: begin
                    wrPend_ff <= 1'b0;
                    hrdata_ff <= isFuse(addr_ff) ? memRd : ctrlRd_ff;
                    hreadyout_ff <= 1'b1;
                    busState_ff <= plr_pkg::BUS_IDLE;
                end
                default: begin
                    wrPend_ff <= 1'b0;
                    hreadyout_ff <= 1'b1;
                    busState_ff <= plr_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hrdata = hrdata_ff;
    assign hresp = hresp_ff;
    assign ioOe = ioOe_ff;
endmodule

// File: verification/plr_fabric_asserts.sv
// Purpose: Port-level checks of the macrocell fabric
// Assumes: hready is looped from hreadyout; aligned single-word transfers
// Notes: Follows the security bit itself, since it cannot see the fuse store
`timescale 1ns/1ns
module plr_fabric_asserts (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    // Pins
    input wire logic [plr_pkg::NUM_IO-1:0] ioOut,
    input wire logic [plr_pkg::NUM_IO-1:0] ioOe
);
    logic [11:0] dAddr_ff;
    logic dWr_ff;
    logic dVld_ff;
    logic sec_ff;
    logic [9:0] evenQ;
    wire take = hsel && htrans[1] && hready;
    wire rdDone = dVld_ff && !dWr_ff && hreadyout;
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            evenQ[i] = hrdata[2*i];
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dVld_ff <= 1'b0;
            sec_ff <= 1'b0;
        end else begin
            if (dVld_ff && dWr_ff && dAddr_ff == plr_pkg::REG_SECURE_OFS && hwdata[0]) begin
                sec_ff <= 1'b1;
            end
            if (take) begin
                dAddr_ff <= haddr[11:0];
                dWr_ff <= hwrite;
                dVld_ff <= 1'b1;
            end else if (hreadyout) begin
                dVld_ff <= 1'b0;
            end
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 !hreadyout ##1 hreadyout)
        else $error("read wait states wrong");
    a_write_nowait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    a_reset_idle: assert property (disable iff (1'b0)
        sys_rst |=> hreadyout && hrdata == 32'h0 && ioOut == 10'h0)
        else $error("outputs not idle after reset");
    a_state_pins: assert property (rdDone && dAddr_ff == plr_pkg::REG_STATE_OFS
        && $stable(ioOut) && ioOut == $past(ioOut, 2) && ioOut == $past(ioOut, 3)
        |-> hrdata[31:20] == 12'h0 && evenQ == ioOut) else $error("state word disagrees");
    a_oe_word: assert property (rdDone && dAddr_ff == plr_pkg::REG_OESTATE_OFS
        && $stable(ioOe) && ioOe == $past(ioOe, 2) && ioOe == $past(ioOe, 3)
        |-> hrdata == {22'h0, ioOe}) else $error("enable word disagrees");
    a_mask_fuse: assert property (rdDone && sec_ff && dAddr_ff < 12'h444
        |-> hrdata == plr_pkg::MASK_WORD) else $error("fuse word not masked");
    a_mask_cfg: assert property (rdDone && sec_ff && (dAddr_ff == plr_pkg::REG_TYPE_OFS
        || dAddr_ff == plr_pkg::REG_CLKSEL_OFS) |-> hrdata == 32'h000fffff)
        else $error("config word not masked");
    a_unmapped_zero: assert property (rdDone && ((dAddr_ff >= 12'h444 && dAddr_ff < 12'h800)
        || dAddr_ff > 12'h810) |-> hrdata == 32'h0) else $error("unmapped read not zero");
endmodule

// File: verification/plr_board.sv
// Purpose: Board logic driving the fabric's input pins and clock pin
// Assumes: Pin changes launch just after a clk_sys edge
// Notes: gap sets how slowly the board moves; undriven I/O pins show a moving pattern
`timescale 1ns/1ns
module plr_board (
    // Clock
    input wire logic clk_sys,
    // From the fabric
    input wire logic [plr_pkg::NUM_IO-1:0] ioOut,
    input wire logic [plr_pkg::NUM_IO-1:0] ioOe,
    // To the fabric
    output logic clkPin,
    output logic [plr_pkg::NUM_DIN-1:0] inPin,
    output logic [plr_pkg::NUM_IO-1:0] ioIn
);
    logic [11:0] pinLvl = 12'h000;
    logic [9:0] noise = 10'h155;
    int gap = 2;
    always @(posedge clk_sys) begin
        noise <= {noise[8:0], noise[9] ^ noise[6]};
    end
    assign clkPin = pinLvl[11];
    assign inPin = {noise[3:0], pinLvl[6:0]};
    assign ioIn = (ioOe & ioOut) | (~ioOe & noise);
    task automatic drive(input int k, input logic v);
        @(posedge clk_sys);
        pinLvl[k] <= v;
        repeat (gap) @(posedge clk_sys);
    endtask
    task automatic pulse(input int k);
        drive(k, 1'b1);
        drive(k, 1'b0);
    endtask
    // Preset only lands on a register clock edge, so both clock sources rise under it
    task automatic preset();
        drive(4, 1'b1);
        pinLvl[11] <= 1'b1;
        pinLvl[2] <= 1'b1;
        repeat (gap) @(posedge clk_sys);
        pinLvl <= pinLvl & 12'h7eb;
        repeat (gap) @(posedge clk_sys);
    endtask
endmodule

// File: verification/test_programmable_register_macrocells.sv
// Purpose: Self-checking bench for the macrocell fabric
// Assumes: A monitor checks each read against the oldest queued expectation
// Notes: Pins come from the board model; hready is looped from hreadyout
`timescale 1ns/1ns
module test_programmable_register_macrocells;
    localparam logic [11:0] aTY = plr_pkg::REG_TYPE_OFS;
    localparam logic [11:0] aCS = plr_pkg::REG_CLKSEL_OFS;
    localparam logic [11:0] aSC = plr_pkg::REG_SECURE_OFS;
    localparam logic [11:0] aST = plr_pkg::REG_STATE_OFS;
    localparam logic [11:0] aOE = plr_pkg::REG_OESTATE_OFS;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic clkPin;
    logic [10:0] inPin;
    logic [9:0] ioIn;
    logic [9:0] ioOut;
    logic [9:0] ioOe;
    logic rdPend = 1'b0;
    logic [31:0] expQ[$];
    logic [31:0] rnd = 32'h2621;
    logic [43:0] rstTab[8] = '{{aTY, 32'h0}, {aCS, 32'h0}, {aSC, 32'h0}, {aST, 32'h0},
        {aOE, 32'h3ff}, {12'h000, 32'h0}, {12'h444, 32'h0}, {12'h900, 32'h0}};
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    always #4 clk_sys = ~clk_sys;
    plr_fabric dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .clkPin(clkPin),
        .inPin(inPin), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));
    plr_board brd (.clk_sys(clk_sys), .ioOut(ioOut), .ioOe(ioOe), .clkPin(clkPin),
        .inPin(inPin), .ioIn(ioIn));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic results();
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cmpRd(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        ahb(a, 1'b1, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        expQ.push_back(e);
        ahb(a, 1'b0, 32'h0);
    endtask
    // Clock term goes in before the reset term is freed, so no stray edge is seen
    task automatic cfgReg(input int r, input logic [31:0] rstWord);
        logic [11:0] b;
        b = 12'(48 * r);
        wr(b, 32'h1);
        wr(b + 12'h00c, 32'h3);
        wr(b + 12'h024, 32'h10);
        wr(b + 12'h018, rstWord);
    endtask
    always @(posedge clk_sys) begin
        if (rdPend && hreadyout === 1'b1) begin
            cmpRd(hrdata, expQ.pop_front());
        end
        rdPend <= (htrans[1] && !hwrite && hreadyout === 1'b1) || (rdPend && hreadyout !== 1'b1);
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        foreach (rstTab[i]) rd(rstTab[i][43:32], rstTab[i][31:0]);
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            wr(12'h1e0 + 12'(12 * i), rnd);
            rd(12'h1e0 + 12'(12 * i), rnd);
        end
        cfgReg(0, 32'h4);
        cfgReg(1, 32'h1000);
        cfgReg(2, 32'h4);
        wr(12'h3c0, 32'h40);
        wr(12'h438, 32'h100);
        wr(aTY, 32'h4);
        wr(aCS, 32'h6);
        rd(aTY, 32'h4);
        rd(aCS, 32'h6);
        rd(aOE, 32'h3fe);
        brd.drive(0, 1'b1);
        brd.pulse(11);
        rd(aST, 32'h6);
        brd.pulse(2);
        rd(aST, 32'h7);
        brd.drive(0, 1'b0);
        brd.pulse(11);
        rd(aST, 32'h5);
        brd.drive(0, 1'b1);
        brd.pulse(11);
        rd(aST, 32'h3);
        brd.drive(1, 1'b1);
        rd(aST, 32'h2);
        brd.pulse(11);
        brd.pulse(2);
        rd(aST, 32'h2);
        brd.drive(1, 1'b0);
        brd.gap = 4;
        brd.pulse(6);
        rd(aST, 32'h0);
        brd.preset();
        rd(aST, 32'h7);
        brd.drive(1, 1'b1);
        brd.preset();
        rd(aST, 32'h2);
        brd.drive(1, 1'b0);
        brd.drive(3, 1'b1);
        brd.drive(5, 1'b1);
        rd(aOE, 32'h3ff);
        wr(aSC, 32'h1);
        rd(aSC, 32'h1);
        rd(aTY, 32'h000fffff);
        rd(aCS, 32'h000fffff);
        rd(12'h000, 32'hffffffff);
        rd(aST, 32'h2);
        @(posedge clk_sys);
        results();
    end
endmodule
bind plr_fabric plr_fabric_asserts chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ioOut(ioOut), .ioOe(ioOe));
